// ===== hdl/dac_ctrl.sv
// Dual 8-bit ladder converter code and standby control with an AXI4-Lite register slave
`timescale 1ns/1ps
module dac_ctrl
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_mode,
  input wire logic stop_float_enable,
  input wire logic [1:0] port14_direction_reg,
  input wire logic [1:0] port14_altfunc_reg,
  output logic [7:0] analog_out_ch0,
  output logic [7:0] analog_out_ch1,
  output logic [1:0] analog_enable,
  output logic [1:0] ladder_power,
  output logic [1:0] pin_drive_ground,
  output logic [1:0] pin_float
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    logic aw_held;
    logic [9:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic keep_on;
    logic [7:0] code0;
    logic [7:0] code1;
    logic [1:0] stop_sync;
    logic [1:0] float_sync;
    logic [1:0] halted;
    logic [1:0] floating;
    // Set through the whole STOP stay so keep-on and float are only looked at on entry
    logic stop_seen;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic do_write;
  logic [7:0] wbyte;
  logic stop_now;
  logic stop_entry;
  logic [1:0] code_nz;
  logic [1:0] alt_sel;

  always_comb
  begin
    code_nz = {s_q.code1 != 8'h00, s_q.code0 != 8'h00};
    alt_sel = port14_direction_reg & port14_altfunc_reg;
  end

  // ----------------------------------------
  // Bus slave and registers
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    s_axi_wready = !s_q.w_held && !s_q.bvalid;
    s_axi_arready = !s_q.rvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    do_write = s_q.aw_held && s_q.w_held;
    wbyte = s_q.w_data[7:0];
    if (do_write)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = dac_ctrl_pkg::RESP_OKAY;
      unique case ({s_q.aw_addr[9:2], 2'b00})
        dac_ctrl_pkg::ADDR_STANDBY_CTRL:
        begin
          if (s_q.w_strb[0])
            s_d.keep_on = wbyte[dac_ctrl_pkg::KEEP_ON_BIT];
        end
        dac_ctrl_pkg::ADDR_CODE_CH0:
        begin
          if (s_q.w_strb[0])
            s_d.code0 = wbyte;
        end
        dac_ctrl_pkg::ADDR_CODE_CH1:
        begin
          if (s_q.w_strb[0])
            s_d.code1 = wbyte;
        end
        dac_ctrl_pkg::ADDR_PORT_READ: ;
        default: s_d.bresp = dac_ctrl_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = dac_ctrl_pkg::RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[9:2], 2'b00})
        dac_ctrl_pkg::ADDR_STANDBY_CTRL:
          s_d.rdata[7:0] = {dac_ctrl_pkg::STANDBY_UPPER_ONES, s_q.keep_on};
        dac_ctrl_pkg::ADDR_CODE_CH0: s_d.rdata[7:0] = s_q.code0;
        dac_ctrl_pkg::ADDR_CODE_CH1: s_d.rdata[7:0] = s_q.code1;
        // Port data bits for the two analog pins: one whenever routed to the converter
        dac_ctrl_pkg::ADDR_PORT_READ: s_d.rdata[1:0] = alt_sel;
        default: s_d.rresp = dac_ctrl_pkg::RESP_SLVERR;
      endcase
    end

    // ----------------------------------------
    // Standby handling
    // ----------------------------------------
    s_d.stop_sync = {s_q.stop_sync[0], stop_mode};
    s_d.float_sync = {s_q.float_sync[0], stop_float_enable};
    stop_now = s_q.stop_sync[1];
    stop_entry = stop_now && !s_q.stop_seen;
    s_d.stop_seen = stop_now;
    if (!stop_now)
    begin
      s_d.halted = 2'b00;
      s_d.floating = 2'b00;
    end
    else if (stop_entry && !s_q.keep_on)
    begin
      s_d.halted = 2'b11;
      s_d.floating = s_q.float_sync[1] ? 2'b11 : 2'b00;
    end
    if (!aresetn)
    begin
      s_d = '0;
      s_d.keep_on = dac_ctrl_pkg::RST_STANDBY_CTRL[dac_ctrl_pkg::KEEP_ON_BIT];
      s_d.code0 = dac_ctrl_pkg::RST_CODE;
      s_d.code1 = dac_ctrl_pkg::RST_CODE;
    end
  end

  always_ff @(posedge aclk)
  begin
    s_q <= s_d;
  end

  // ----------------------------------------
  // Analog side
  // ----------------------------------------
  // Level on each pin is supply times code over 256, so code FF stays one step short
  assign analog_out_ch0 = s_q.code0;
  assign analog_out_ch1 = s_q.code1;

  genvar ch;
  generate
    for (ch = 0; ch < dac_ctrl_pkg::NUM_CH; ch++)
    begin : g_ch
      // Halted or unpowered ladder carries no current; keep-on one never halts
      assign ladder_power[ch] = code_nz[ch] && !s_q.halted[ch];
      assign analog_enable[ch] = alt_sel[ch] && !s_q.halted[ch];
      assign pin_drive_ground[ch] = alt_sel[ch] && !s_q.halted[ch] && !code_nz[ch];
      assign pin_float[ch] = s_q.floating[ch];
    end
  endgenerate

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;

endmodule : dac_ctrl

// ===== hdl/dac_ctrl_pkg.sv
// Package: register map, reset values and field positions of the dual converter control
package dac_ctrl_pkg;
  // Register byte addresses (printed offsets are not all multiples of four: index times four)
  localparam logic [7:0] IDX_STANDBY_CTRL = 8'hDD;
  localparam logic [7:0] IDX_CODE_CH0 = 8'hDE;
  localparam logic [7:0] IDX_CODE_CH1 = 8'hDF;
  localparam logic [7:0] IDX_PORT_READ = 8'hE0;
  localparam logic [9:0] ADDR_STANDBY_CTRL = {IDX_STANDBY_CTRL, 2'b00};
  localparam logic [9:0] ADDR_CODE_CH0 = {IDX_CODE_CH0, 2'b00};
  localparam logic [9:0] ADDR_CODE_CH1 = {IDX_CODE_CH1, 2'b00};
  localparam logic [9:0] ADDR_PORT_READ = {IDX_PORT_READ, 2'b00};
  localparam int ADDR_W = 10;
  // Reset values
  localparam logic [7:0] RST_STANDBY_CTRL = 8'hFE;
  localparam logic [7:0] RST_CODE = 8'h00;
  // Field positions
  localparam int KEEP_ON_BIT = 0;
  localparam logic [6:0] STANDBY_UPPER_ONES = 7'h7F;
  localparam int CODE_W = 8;
  localparam int NUM_CH = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dac_ctrl_pkg

// ===== tb/pin_load.sv
// Far-side model: software port setup for the two pins
`timescale 1ns/1ps
module pin_load
(
  input wire logic cfg,
  output logic [1:0] port14_direction_reg,
  output logic [1:0] port14_altfunc_reg
);
  assign port14_direction_reg = {2{cfg}};
  assign port14_altfunc_reg = {2{cfg}};
endmodule : pin_load

// ===== tb/dac_ctrl_asserts.sv
// Checker of the converter control port relations
`timescale 1ns/1ps
module dac_ctrl_asserts
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] port14_direction_reg,
  input wire logic [1:0] port14_altfunc_reg,
  input wire logic [7:0] analog_out_ch0,
  input wire logic [7:0] analog_out_ch1,
  input wire logic [1:0] analog_enable,
  input wire logic [1:0] ladder_power,
  input wire logic [1:0] pin_drive_ground,
  input wire logic [1:0] pin_float
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_power_nonzero: assert property (ladder_power[0] |-> analog_out_ch0 != 8'h00)
    else $error("power without code");
  a_ground_zero: assert property (pin_drive_ground[1] |-> analog_out_ch1 == 8'h00 && !ladder_power[1])
    else $error("ground with code");
  a_ground_route: assert property (pin_drive_ground[0] |-> analog_enable[0])
    else $error("ground not routed");
  a_route_needed: assert property (analog_enable[0] |-> port14_direction_reg[0] && port14_altfunc_reg[0])
    else $error("output not routed");
  a_float_quiet: assert property (|pin_float |-> analog_enable == 2'h0 && ladder_power == 2'h0)
    else $error("float while driving");
  a_code_reset: assert property (disable iff (1'h0) !aresetn |=> analog_out_ch0 == 8'h00 && analog_out_ch1 == 8'h00)
    else $error("code kept over reset");
  a_code_write: assert property ($changed(analog_out_ch1) |-> $rose(s_axi_bvalid))
    else $error("code change without write");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("response dropped");
endmodule : dac_ctrl_asserts
bind dac_ctrl dac_ctrl_asserts i_chk (.*);

// ===== tb/tb_top.sv
// Register and pin tests of the converter control
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic stop_mode = 1'h0, stop_float_enable = 1'h0, cfg = 1'h0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, port14_direction_reg, port14_altfunc_reg;
  logic [1:0] analog_enable, ladder_power, pin_drive_ground, pin_float;
  logic [7:0] analog_out_ch0, analog_out_ch1;
  int mismatches = 0, compares = 0;
  dac_ctrl i_dut (.*);
  pin_load i_load (.*);
  initial forever #12.5 aclk = ~aclk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [31:0] d);
    logic ta, tw, bd;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready; tw = s_axi_wvalid & s_axi_wready; bd = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!bd);
    s_axi_bready <= 1'h0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ta, rv;
    logic [31:0] g;
    logic [1:0] p;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready; rv = s_axi_rvalid; g = s_axi_rdata; p = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (!rv);
    s_axi_rready <= 1'h0;
    chk(g, e);
    chk({30'h0, p}, {30'h0, r});
  endtask : rd
  task stp(input logic s, input logic f);
    @(posedge aclk);
    stop_mode <= s; stop_float_enable <= f;
    repeat (6) @(negedge aclk);
  endtask : stp
  task give_verdict;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(dac_ctrl_pkg::ADDR_STANDBY_CTRL, 32'hFE, dac_ctrl_pkg::RESP_OKAY);
    rd(dac_ctrl_pkg::ADDR_CODE_CH1, 32'h0, dac_ctrl_pkg::RESP_OKAY);
    rd(10'h004, 32'h0, dac_ctrl_pkg::RESP_SLVERR);
    wr(dac_ctrl_pkg::ADDR_STANDBY_CTRL, 32'h0);
    rd(dac_ctrl_pkg::ADDR_STANDBY_CTRL, 32'hFE, dac_ctrl_pkg::RESP_OKAY);
    wr(dac_ctrl_pkg::ADDR_STANDBY_CTRL, 32'hFF);
    rd(dac_ctrl_pkg::ADDR_STANDBY_CTRL, 32'hFF, dac_ctrl_pkg::RESP_OKAY);
    wr(dac_ctrl_pkg::ADDR_CODE_CH0, 32'h5A);
    wr(dac_ctrl_pkg::ADDR_CODE_CH1, 32'hFF);
    @(negedge aclk);
    chk({16'h0, analog_out_ch1, analog_out_ch0}, 32'hFF5A);
    chk({30'h0, analog_enable}, 32'h0);
    @(posedge aclk);
    cfg <= 1'h1;
    rd(dac_ctrl_pkg::ADDR_PORT_READ, 32'h3, dac_ctrl_pkg::RESP_OKAY);
    stp(1'h1, 1'h0);
    chk({28'h0, analog_enable, ladder_power}, 32'hF);
    wr(dac_ctrl_pkg::ADDR_STANDBY_CTRL, 32'h0);
    repeat (4) @(negedge aclk);
    chk({28'h0, analog_enable, ladder_power}, 32'hF);
    stp(1'h0, 1'h0);
    wr(dac_ctrl_pkg::ADDR_STANDBY_CTRL, 32'h0);
    stp(1'h1, 1'h0);
    chk({12'h0, analog_out_ch1, analog_out_ch0, analog_enable, ladder_power}, 32'hFF5A0);
    stp(1'h0, 1'h0);
    wr(dac_ctrl_pkg::ADDR_CODE_CH1, 32'h0);
    @(negedge aclk);
    chk({28'h0, pin_drive_ground, ladder_power}, 32'h9);
    stp(1'h0, 1'h1);
    stp(1'h1, 1'h1);
    chk({30'h0, pin_float}, 32'h3);
    stp(1'h0, 1'h0);
    rd(dac_ctrl_pkg::ADDR_CODE_CH0, 32'h5A, dac_ctrl_pkg::RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk({16'h0, analog_out_ch1, analog_out_ch0}, 32'h0);
    give_verdict();
  end
endmodule : tb_top
